// *** common/shc_pkg.sv ***
// Constants, types and register layout for the serial host/client shift engine.
// Assumes a single 25 MHz core clock and a plain strobe register port.
// Behaviour
// [R1] Host starts a cycle by pulling client select low, then clocks data; the core drives select high only, so it never lowers it.
// [R2] Data goes host to client on host-out, client to host on host-in.
// [R3] One 8-bit shift register shifts a bit out and a bit in together.
// [R4] Data write loads shift register in Normal, transmit buffer in Buffer mode.
// [R5] Data read returns receive register in Normal, receive FIFO head in Buffer.
// [R6] Host makes serial clock from divider; client syncs and samples incoming clock.
// [R7] When enabled, force host-in (host) or host-out, clock, select (client) to input.
// [R8] Pins set to output by software are driven from the shift logic.
// [R9] Client drives host-in line only while select is low, else floats it.
// [R10] Software configures everything before finally setting the enable bit.
// [R11] In host mode each data write starts a new byte transfer.
// [R12] Host Normal write during transfer corrupts the byte and flags collision.
// [R13] Normal mode copies received byte to receive register at completion.
// [R14] Normal mode software reads each byte before the next one completes.
// [R15] Normal completion sets transfer-done flag; interrupt when enabled globally too.
// [R16] Buffer-enable bit selects Buffer mode; wait-for-receive bit ignored in host.
// [R17] Host Buffer: first write transmits at once, next waits in holding buffer.
// [R18] Buffer mode pushes each received byte into a two-entry receive FIFO.
// [R19] Buffer mode software pops the FIFO at least every second transfer.
// [R20] Buffer mode sets transmit-complete when shift register and buffer are empty.
// [R21] Data-empty flag clears on buffer write, sets when buffer moves to shifter.
// [R22] Host with select enabled as input: low select drops to client, flags done.
// [R23] Transfer-mode field picks clock idle level and sampling edge.
package shc_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [2:0] SHC_OFF_PRIMARY = 3'h0;
	localparam logic [2:0] SHC_OFF_SECONDARY = 3'h1;
	localparam logic [2:0] SHC_OFF_IRQ_CTRL = 3'h2;
	localparam logic [2:0] SHC_OFF_FLAGS = 3'h3;
	localparam logic [2:0] SHC_OFF_DATA = 3'h4;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int SHC_PRI_ENABLE = 0;
	localparam int SHC_PRI_DIV_LO = 1;
	localparam int SHC_PRI_DOUBLE = 4;
	localparam int SHC_PRI_HOST = 5;
	localparam int SHC_PRI_LSB_FIRST = 6;
	localparam int SHC_SEC_MODE_LO = 0;
	localparam int SHC_SEC_SEL_DIS = 2;
	localparam int SHC_SEC_WAIT_RX = 6;
	localparam int SHC_SEC_BUF_EN = 7;
	localparam int SHC_IRQ_DONE_EN = 0;
	localparam int SHC_IRQ_TXC_EN = 6;
	localparam int SHC_FLG_DONE = 0;
	localparam int SHC_FLG_COLL = 1;
	localparam int SHC_FLG_TXC = 2;
	localparam int SHC_FLG_DRE = 3;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0] SHC_RST_BYTE = 8'h00;
	localparam logic [3:0] SHC_LAST_EDGE = 4'hf;
	// Half periods of serial clock, in core cycles, per divider code
	localparam logic [6:0] SHC_HALF_DIV4 = 7'h02;
	localparam logic [6:0] SHC_HALF_DIV16 = 7'h08;
	localparam logic [6:0] SHC_HALF_DIV64 = 7'h20;
	localparam logic [6:0] SHC_HALF_DIV128 = 7'h40;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss;
	} shc_pins_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} shc_bus_t;

endpackage

// *** design/shc_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module shc_sync
	import shc_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;

	// Idle-high reset keeps select and clock from looking active
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta_q <= '1;
			sync_o <= '1;
		end
		else
		begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

// *** design/shc_clkgen.sv ***
// Serial clock tick generator for host mode.
// Assumes run stays high for a whole transfer; restarts from zero when low.
`timescale 1ns/1ps
module shc_clkgen
	import shc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic run,
	input wire logic [1:0] div_sel,
	input wire logic double_rate,
	output logic tick
);

	logic [6:0] cnt_q;
	logic [6:0] half;

	// ----------------------------------------
	// Divider select
	// ----------------------------------------
	always_comb
	begin
		case (div_sel)
			2'h0: half = SHC_HALF_DIV4;
			2'h1: half = SHC_HALF_DIV16;
			2'h2: half = SHC_HALF_DIV64;
			default: half = SHC_HALF_DIV128;
		endcase
		if (double_rate)
			half = {1'b0, half[6:1]};
	end

	assign tick = run && (cnt_q == half - 7'h01); // R6

	always_ff @(posedge clk)
	begin
		if (srst || !run || tick)
			cnt_q <= 7'h00;
		else
			cnt_q <= cnt_q + 7'h01;
	end

endmodule

// *** design/shc_core.sv ***
// Serial host/client shift engine with registers, pin control and buffering.
// Assumes pins sit behind an external port with software-set directions.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module shc_core
	import shc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire shc_bus_t bus,
	output logic [7:0] rdata,
	input wire shc_pins_t pin_i,
	input wire shc_pins_t pin_dir,
	output shc_pins_t pin_o,
	output shc_pins_t pin_oe,
	input wire logic global_irq_en,
	output logic irq
);

	// ----------------------------------------
	// Registers and decoded controls
	// ----------------------------------------
	logic [7:0] primary_control_register_q;
	logic [7:0] secondary_control_register_q;
	logic [7:0] irq_control_register_q;
	logic transfer_done_q;
	logic write_collision_flag_q;
	logic transmit_complete_flag_q;
	logic [7:0] shr_q;
	logic [7:0] txbuf_q;
	logic txbuf_v_q;
	logic [7:0] rx0_q;
	logic [7:0] rx1_q;
	logic [1:0] rx_cnt_q;
	logic [3:0] edge_cnt_q;
	logic busy_q;
	logic sck_lvl_q;
	logic out_q;
	logic sck_prev_q;

	logic enable, host, double_rate_bit, bit_order_select, cpol, cpha;
	logic select_disable_bit, buffer_enable_bit, wait_for_receive_bit;
	logic [1:0] clock_divider_field;
	logic data_register_empty_flag;

	assign enable = primary_control_register_q[SHC_PRI_ENABLE];
	assign clock_divider_field = primary_control_register_q[SHC_PRI_DIV_LO +: 2];
	assign double_rate_bit = primary_control_register_q[SHC_PRI_DOUBLE];
	assign host = primary_control_register_q[SHC_PRI_HOST];
	assign bit_order_select = primary_control_register_q[SHC_PRI_LSB_FIRST];
	assign cpol = secondary_control_register_q[SHC_SEC_MODE_LO + 1]; // R23
	assign cpha = secondary_control_register_q[SHC_SEC_MODE_LO]; // R23
	assign select_disable_bit = secondary_control_register_q[SHC_SEC_SEL_DIS];
	// Kept for software; only client buffering would use it
	assign wait_for_receive_bit = secondary_control_register_q[SHC_SEC_WAIT_RX]; // R16
	assign buffer_enable_bit = secondary_control_register_q[SHC_SEC_BUF_EN]; // R16
	assign data_register_empty_flag = !txbuf_v_q;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	shc_pins_t pin_s;

	shc_sync #(.WIDTH(4)) u_sync (
		.clk(clk),
		.srst(srst),
		.async_i(pin_i),
		.sync_o(pin_s)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic wr_pri, wr_sec, wr_irq, wr_flg, wr_data, rd_data;

	assign wr_pri = bus.we && bus.addr == SHC_OFF_PRIMARY;
	assign wr_sec = bus.we && bus.addr == SHC_OFF_SECONDARY;
	assign wr_irq = bus.we && bus.addr == SHC_OFF_IRQ_CTRL;
	assign wr_flg = bus.we && bus.addr == SHC_OFF_FLAGS;
	assign wr_data = bus.we && bus.addr == SHC_OFF_DATA;
	assign rd_data = bus.re && bus.addr == SHC_OFF_DATA;

	// ----------------------------------------
	// Shift event generation
	// ----------------------------------------
	logic host_act, client_act, tick, cl_edge, edge_ev, sample_edge, done;
	logic in_bit, sel_lost;
	logic [7:0] shr_shift, done_byte;

	assign host_act = enable && host;
	assign client_act = enable && !host;

	shc_clkgen u_clkgen (
		.clk(clk),
		.srst(srst),
		.run(busy_q && host_act),
		.div_sel(clock_divider_field),
		.double_rate(double_rate_bit),
		.tick(tick)
	);

	// Client clock edges only count while selected
	assign cl_edge = client_act && !pin_s.ss && (pin_s.sck != sck_prev_q); // R6
	assign edge_ev = host_act ? (busy_q && tick) : cl_edge;
	assign sample_edge = edge_cnt_q[0] == cpha; // R23
	assign done = edge_ev && edge_cnt_q == SHC_LAST_EDGE;
	assign in_bit = host_act ? pin_s.miso : pin_s.mosi; // R2

	// One bit in per sample edge, next bit exposed at the far end
	assign shr_shift = bit_order_select ? {in_bit, shr_q[7:1]} : {shr_q[6:0], in_bit}; // R3
	assign done_byte = cpha ? shr_shift : shr_q;

	// Another host pulling select low takes the bus from us
	assign sel_lost = host_act && !select_disable_bit && !pin_dir.ss && !pin_s.ss; // R22

	function automatic logic first_bit(input logic [7:0] v, input logic lsb);
		first_bit = lsb ? v[0] : v[7];
	endfunction

	always_ff @(posedge clk)
	begin
		// Matches the synchroniser's reset level so no false edge follows reset
		if (srst)
			sck_prev_q <= 1'b1;
		else
			sck_prev_q <= pin_s.sck;
	end

	// ----------------------------------------
	// Data write decisions
	// ----------------------------------------
	logic cl_busy, host_start, host_coll, to_buf, next_from_buf;

	assign cl_busy = client_act && edge_cnt_q != 4'h0;
	assign host_start = wr_data && host_act && (buffer_enable_bit ? (!busy_q && !txbuf_v_q) : 1'b1); // R11 R17
	assign host_coll = wr_data && host_act && !buffer_enable_bit && busy_q; // R12
	assign to_buf = wr_data && buffer_enable_bit && !txbuf_v_q && !host_start; // R4 R17
	assign next_from_buf = done && buffer_enable_bit && txbuf_v_q; // R21

	// ----------------------------------------
	// Shift register, bit counter, clock level
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			shr_q <= SHC_RST_BYTE;
			out_q <= 1'b0;
		end
		else if (host_coll)
		begin
			// Overwrites the byte mid-flight; the sent byte is garbage
			shr_q <= bus.wdata; // R12
		end
		else if (host_start || (wr_data && client_act && !buffer_enable_bit && !cl_busy))
		begin
			shr_q <= bus.wdata; // R4
			if (!cpha)
				out_q <= first_bit(bus.wdata, bit_order_select);
		end
		else if (next_from_buf)
		begin
			shr_q <= txbuf_q; // R17
			if (!cpha)
				out_q <= first_bit(txbuf_q, bit_order_select);
		end
		else if (edge_ev && sample_edge)
			shr_q <= shr_shift; // R3
		else if (edge_ev)
			out_q <= first_bit(shr_q, bit_order_select);
		else if (client_act && edge_cnt_q == 4'h0 && !cpha)
			out_q <= first_bit(shr_q, bit_order_select);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			edge_cnt_q <= 4'h0;
		else if (host_start || !enable || (client_act && pin_s.ss)) // R9
			edge_cnt_q <= 4'h0;
		else if (edge_ev)
			edge_cnt_q <= edge_cnt_q + 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			busy_q <= 1'b0;
		else if (!host_act || sel_lost)
			busy_q <= 1'b0;
		else if (host_start)
			busy_q <= 1'b1; // R11
		else if (done)
			busy_q <= next_from_buf;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			sck_lvl_q <= 1'b0;
		else if (!busy_q)
			sck_lvl_q <= cpol; // R23
		else if (edge_ev)
			sck_lvl_q <= !sck_lvl_q; // R6
	end

	// ----------------------------------------
	// Transmit holding buffer
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			txbuf_q <= SHC_RST_BYTE;
			txbuf_v_q <= 1'b0;
		end
		else if (!buffer_enable_bit)
			txbuf_v_q <= 1'b0; // R13
		else if (to_buf)
		begin
			txbuf_q <= bus.wdata;
			txbuf_v_q <= 1'b1; // R21
		end
		else if (next_from_buf)
			txbuf_v_q <= 1'b0; // R21
	end

	// ----------------------------------------
	// Receive register and FIFO
	// ----------------------------------------
	logic pop;

	assign pop = rd_data && buffer_enable_bit && rx_cnt_q != 2'h0;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rx0_q <= SHC_RST_BYTE;
			rx1_q <= SHC_RST_BYTE;
			rx_cnt_q <= 2'h0;
		end
		else if (!buffer_enable_bit)
		begin
			rx_cnt_q <= 2'h0;
			if (done)
				rx0_q <= done_byte; // R13
		end
		else if (done)
		begin
			// Full FIFO loses the newest stored byte if software falls behind
			if (rx_cnt_q == 2'h0 || (pop && rx_cnt_q == 2'h1))
				rx0_q <= done_byte; // R18
			else if (pop)
			begin
				rx0_q <= rx1_q;
				rx1_q <= done_byte; // R18
			end
			else
				rx1_q <= done_byte; // R18
			if (!pop && rx_cnt_q != 2'h2)
				rx_cnt_q <= rx_cnt_q + 2'h1;
		end
		else if (pop)
		begin
			rx0_q <= rx1_q;
			rx_cnt_q <= rx_cnt_q - 2'h1;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			primary_control_register_q <= SHC_RST_BYTE;
		else
		begin
			if (wr_pri)
				primary_control_register_q <= bus.wdata; // R10
			if (sel_lost)
				primary_control_register_q[SHC_PRI_HOST] <= 1'b0; // R22
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			secondary_control_register_q <= SHC_RST_BYTE;
			irq_control_register_q <= SHC_RST_BYTE;
		end
		else
		begin
			if (wr_sec)
				secondary_control_register_q <= bus.wdata;
			if (wr_irq)
				irq_control_register_q <= bus.wdata;
		end
	end

	// ----------------------------------------
	// Flags: write one to clear, a set in the same cycle wins
	// ----------------------------------------
	logic set_done, set_coll, set_txc;

	assign set_done = (done && !buffer_enable_bit) || sel_lost; // R15 R22
	assign set_coll = host_coll || (wr_data && client_act && !buffer_enable_bit && cl_busy); // R12
	assign set_txc = done && buffer_enable_bit && !txbuf_v_q; // R20

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			transfer_done_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			transmit_complete_flag_q <= 1'b0;
		end
		else
		begin
			transfer_done_q <= set_done || (transfer_done_q && !(wr_flg && bus.wdata[SHC_FLG_DONE]));
			write_collision_flag_q <= set_coll || (write_collision_flag_q && !(wr_flg && bus.wdata[SHC_FLG_COLL]));
			transmit_complete_flag_q <= set_txc ||
				(transmit_complete_flag_q && !(wr_flg && bus.wdata[SHC_FLG_TXC]));
		end
	end

	assign irq = global_irq_en && ((transfer_done_q && irq_control_register_q[SHC_IRQ_DONE_EN]) || // R15
		(transmit_complete_flag_q && irq_control_register_q[SHC_IRQ_TXC_EN])); // R20

	// ----------------------------------------
	// Read data, valid the cycle after the strobe
	// ----------------------------------------
	logic [7:0] flags_view;

	always_comb
	begin
		flags_view = 8'h00;
		flags_view[SHC_FLG_DONE] = transfer_done_q;
		flags_view[SHC_FLG_COLL] = write_collision_flag_q;
		flags_view[SHC_FLG_TXC] = transmit_complete_flag_q;
		flags_view[SHC_FLG_DRE] = data_register_empty_flag;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			rdata <= 8'h00;
		else if (bus.re)
			case (bus.addr)
				SHC_OFF_PRIMARY: rdata <= primary_control_register_q;
				SHC_OFF_SECONDARY: rdata <= secondary_control_register_q;
				SHC_OFF_IRQ_CTRL: rdata <= irq_control_register_q;
				SHC_OFF_FLAGS: rdata <= flags_view;
				SHC_OFF_DATA: rdata <= rx0_q; // R5
				default: rdata <= 8'h00;
			endcase
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	always_comb
	begin
		pin_o.sck = sck_lvl_q; // R1
		pin_o.mosi = out_q; // R2
		pin_o.miso = out_q; // R2
		pin_o.ss = 1'b1;
		pin_oe = '0;
		if (host_act)
		begin
			pin_oe.sck = pin_dir.sck; // R8
			pin_oe.mosi = pin_dir.mosi; // R8
			pin_oe.ss = pin_dir.ss; // R8
			pin_oe.miso = 1'b0; // R7
		end
		else if (client_act)
			pin_oe.miso = pin_dir.miso && !pin_s.ss; // R7 R9
	end

endmodule

// *** tb/shc_core_asserts.sv ***
// Checker for the shift engine core, bound to its ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module shc_core_asserts
	import shc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire shc_bus_t bus,
	input wire logic [7:0] rdata,
	input wire shc_pins_t pin_i,
	input wire shc_pins_t pin_dir,
	input wire shc_pins_t pin_o,
	input wire shc_pins_t pin_oe,
	input wire logic global_irq_en,
	input wire logic irq
);
	// ----
	// Shadow of mode bits and serial clock quiet time
	// ----
	logic en_q;
	logic host_q;
	logic sck_q;
	logic [7:0] quiet_q;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// Shadow misses select loss, so the start check also demands select high
	always_ff @(posedge clk)
		if (srst)
			{en_q, host_q} <= 2'b00;
		else if (bus.we && bus.addr == SHC_OFF_PRIMARY)
			{en_q, host_q} <= {bus.wdata[SHC_PRI_ENABLE], bus.wdata[SHC_PRI_HOST]};
	always_ff @(posedge clk)
	begin
		sck_q <= pin_o.sck;
		if (srst || pin_o.sck != sck_q)
			quiet_q <= 8'h00;
		else if (quiet_q != 8'hff)
			quiet_q <= quiet_q + 8'h01;
	end
	// ----
	// Properties
	// ----
	reset_quiet_a: assert property ($past(srst) |-> 4'(pin_oe) == 4'h0 && !irq && rdata == 8'h00)
		else $error("outputs not quiet after reset");
	off_quiet_a: assert property (!en_q |-> 4'(pin_oe) == 4'h0)
		else $error("pin driven while disabled");
	dir_respect_a: assert property ((4'(pin_oe) & ~4'(pin_dir)) == 4'h0)
		else $error("pin driven against its direction");
	role_input_a: assert property (pin_oe.miso |-> !pin_oe.mosi && !pin_oe.sck && !pin_oe.ss)
		else $error("input pin of the role driven");
	miso_select_a: assert property (pin_oe.miso |-> !($past(pin_i.ss) && $past(pin_i.ss, 2) && $past(pin_i.ss, 3)))
		else $error("host-in driven while not selected");
	rdata_hold_a: assert property (!$past(bus.re) |-> $stable(rdata))
		else $error("read data moved without a read");
	irq_global_a: assert property (irq |-> global_irq_en)
		else $error("interrupt without global enable");
	start_clock_a: assert property (bus.we && bus.addr == SHC_OFF_DATA && en_q && host_q
		&& quiet_q[7] && pin_i.ss |-> ##[1:140] $changed(pin_o.sck)) else $error("data write started no transfer");
endmodule
bind shc_core shc_core_asserts i_chk (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .pin_i(pin_i),
	.pin_dir(pin_dir), .pin_o(pin_o), .pin_oe(pin_oe), .global_irq_en(global_irq_en), .irq(irq));

// *** tb/shc_client_model.sv ***
// Behavioural serial client on the far side of the host link.
// Assumes select comes from the bench; sends tx_byte, then its inverse, per frame.
`timescale 1ns/1ps
module shc_client_model
	import shc_pkg::*;
(
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic lsb,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic [7:0] rx_last,
	output logic [7:0] rx_prev
);
	logic [7:0] sh = 8'h00;
	logic [7:0] rx = 8'h00;
	logic fresh = 1'b0;
	logic last_bit = 1'b0;
	int n = 0;
	int k = 0;
	// Released line shows the inverse, never a stale level
	assign miso = sel_n ? ~last_bit : (lsb ? sh[0] : sh[7]);
	initial {rx_last, rx_prev} = 16'h0000;
	always @(negedge sel_n)
	begin
		sh = tx_byte;
		fresh = cpha;
		n = 0;
		k = 0;
	end
	always @(posedge sel_n)
		last_bit = lsb ? sh[0] : sh[7];
	always @(sck)
		if (!sel_n)
		begin
			if ((sck != cpol) ^ cpha)
			begin
				rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
				n++;
				if (n == 8)
				begin
					{rx_prev, rx_last} = {rx_last, rx};
					n = 0;
					k++;
					fresh = 1'b1;
				end
			end
			else
			begin
				sh = fresh ? (k[0] ? ~tx_byte : tx_byte) : (lsb ? sh >> 1 : sh << 1);
				fresh = 1'b0;
			end
		end
endmodule

// *** tb/shc_core_tb_top.sv ***
// Self-checking bench: host Buffer and Normal traffic, collision, select loss, client byte.
// Assumes the package, core, checker and client model are compiled first.
`timescale 1ns/1ps
module shc_core_tb_top
	import shc_pkg::*;
();
	logic clk = 1'b0;
	logic srst = 1'b1;
	shc_bus_t bus = '0;
	logic [7:0] rdata;
	shc_pins_t pin_i;
	shc_pins_t pin_dir = '0;
	shc_pins_t pin_o;
	shc_pins_t pin_oe;
	logic global_irq_en = 1'b0;
	logic irq;
	logic tb_sck = 1'b0;
	logic tb_mosi = 1'b0;
	logic tb_ss = 1'b1;
	logic m_sel_n = 1'b1;
	logic m_miso, cpol, cpha, lsb;
	logic [7:0] m_tx, m_last, m_prev, tx, cl, seen;
	logic [2:0] ra[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
	logic [7:0] rxq[$];
	int num_errors = 0;
	int checks = 0;
	always #20 clk = ~clk;
	// Each pin is the driven level if the core drives it, else the outside party
	assign pin_i = '{sck: pin_oe.sck ? pin_o.sck : tb_sck, mosi: pin_oe.mosi ? pin_o.mosi : tb_mosi,
		miso: pin_oe.miso ? pin_o.miso : m_miso, ss: pin_oe.ss ? pin_o.ss : tb_ss};
	shc_core i_dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata), .pin_i(pin_i), .pin_dir(pin_dir),
		.pin_o(pin_o), .pin_oe(pin_oe), .global_irq_en(global_irq_en), .irq(irq));
	shc_client_model i_client (.sck(pin_i.sck), .mosi(pin_i.mosi), .sel_n(m_sel_n), .cpol(cpol), .cpha(cpha),
		.lsb(lsb), .tx_byte(m_tx), .miso(m_miso), .rx_last(m_last), .rx_prev(m_prev));
	// ----
	// Tasks
	// ----
	task automatic close_out();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] seen_v, input logic [7:0] exp_v);
		checks++;
		if (seen_v !== exp_v)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", s, exp_v, seen_v);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus.we <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		bus.addr <= a;
		bus.re <= 1'b1;
		@(posedge clk);
		bus.re <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string s);
		logic [7:0] v;
		rd(a, v);
		chk(s, v & m, e);
	endtask
	task automatic wait_flag(input int b);
		logic [7:0] f;
		for (int i = 0; i < 600; i++)
		begin
			rd(SHC_OFF_FLAGS, f);
			if (f[b] === 1'b1)
				return;
		end
		num_errors++;
		$display("wrong value flag wait expected 1 seen 0");
		close_out();
	endtask
	task automatic host_cfg(input logic [7:0] sec, input logic [7:0] pri);
		{cpol, cpha, lsb} = {sec[1:0], pri[6]};
		pin_dir <= 4'hd;
		wr(SHC_OFF_SECONDARY, sec);
		wr(SHC_OFF_PRIMARY, pri);
		repeat (140) @(posedge clk);
	endtask
	// ----
	// Main sequence
	// ----
	initial
	begin
		void'($urandom(32'h26b74d09));
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		wr(3'h6, 8'hff);
		for (int j = 0; j < 6; j++)
			rdc(ra[j], 8'hff, 8'h00, "reset read");
		tx = 8'($urandom);
		cl = 8'($urandom);
		host_cfg(8'hc4, 8'h23);
		wr(SHC_OFF_IRQ_CTRL, 8'h40);
		global_irq_en <= 1'b1;
		{m_tx, m_sel_n} = {cl, 1'b0};
		wr(SHC_OFF_DATA, tx);
		wr(SHC_OFF_DATA, ~tx);
		rxq = '{cl, ~cl};
		rdc(SHC_OFF_FLAGS, 8'h0c, 8'h00, "buffer full flags");
		wait_flag(SHC_FLG_TXC);
		m_sel_n = 1'b1;
		chk("first byte", m_prev, tx);
		chk("second byte", m_last, ~tx);
		rdc(SHC_OFF_FLAGS, 8'h09, 8'h08, "empty flags");
		chk("txc irq", {7'h0, irq}, 8'h01);
		rdc(SHC_OFF_DATA, 8'hff, rxq.pop_front(), "fifo head");
		rdc(SHC_OFF_DATA, 8'hff, rxq.pop_front(), "fifo tail");
		wr(SHC_OFF_FLAGS, 8'h07);
		for (int i = 0; i < 4; i++)
		begin
			tx = 8'($urandom);
			cl = 8'($urandom);
			// Sweeps divider codes 1 and 3 and double rate along with the four clock modes
			host_cfg({6'h01, i[1:0]}, {1'b0, i[0] ^ i[1], 1'b1, i[0], 1'b0, i[1], 2'h3});
			wr(SHC_OFF_IRQ_CTRL, 8'h01);
			global_irq_en <= i[0];
			{m_tx, m_sel_n} = {cl, 1'b0};
			wr(SHC_OFF_DATA, tx);
			rxq.push_back(cl);
			wait_flag(SHC_FLG_DONE);
			m_sel_n = 1'b1;
			chk("host out byte", m_last, tx);
			chk("done irq", {7'h0, irq}, {7'h0, i[0]});
			rdc(SHC_OFF_DATA, 8'hff, rxq.pop_front(), "host in byte");
			wr(SHC_OFF_FLAGS, 8'h07);
		end
		host_cfg(8'h04, 8'h23);
		m_sel_n = 1'b0;
		wr(SHC_OFF_DATA, tx);
		repeat (20) @(posedge clk);
		wr(SHC_OFF_DATA, cl);
		wait_flag(SHC_FLG_DONE);
		m_sel_n = 1'b1;
		rdc(SHC_OFF_FLAGS, 8'h02, 8'h02, "collision flag");
		host_cfg(8'h00, 8'h23);
		pin_dir <= 4'hc;
		wr(SHC_OFF_FLAGS, 8'h07);
		tb_ss <= 1'b0;
		repeat (6) @(posedge clk);
		rdc(SHC_OFF_PRIMARY, 8'hff, 8'h03, "host bit");
		rdc(SHC_OFF_FLAGS, 8'h01, 8'h01, "select loss flag");
		tb_ss <= 1'b1;
		pin_dir <= 4'h2;
		wr(SHC_OFF_FLAGS, 8'h07);
		wr(SHC_OFF_PRIMARY, 8'h01);
		wr(SHC_OFF_DATA, tx);
		chk("idle host-in enable", {7'h0, pin_oe.miso}, 8'h00);
		tb_ss <= 1'b0;
		repeat (8) @(posedge clk);
		chk("client enables", 8'(4'(pin_oe)), 8'h02);
		for (int b = 7; b >= 0; b--)
		begin
			tb_mosi <= cl[b];
			repeat (4) @(posedge clk);
			#1 seen[b] = pin_o.miso;
			@(posedge clk);
			tb_sck <= 1'b1;
			repeat (4) @(posedge clk);
			tb_sck <= 1'b0;
		end
		wait_flag(SHC_FLG_DONE);
		chk("client out byte", seen, tx);
		rdc(SHC_OFF_DATA, 8'hff, cl, "client in byte");
		tb_ss <= 1'b1;
		repeat (4) @(posedge clk);
		chk("released host-in", {7'h0, pin_oe.miso}, 8'h00);
		close_out();
	end
endmodule
